/* File: logic/sacrf_core.sv */
// converter configuration, conversion-clock divider, conversion sequencing and result registers
`timescale 1ns/1ps
`default_nettype none
module sacrf_core (
    input wire logic mclk,
    input wire logic rst_n,
    input wire sacrf_pkg::sacrf_sfr_req_type sfr_req,
    output logic [7:0] sfr_rdata,
    input wire logic conv_start,
    input wire logic [9:0] analog_code,
    output logic conversion_clock,
    output logic gain_select,
    output logic conv_busy,
    output logic conv_done
);
    typedef struct packed {
        sacrf_pkg::sacrf_config_type cfg;
        logic [7:0] result_high_byte;
        logic [7:0] result_low_byte;
        logic [7:0] rdata;
        logic [4:0] div_count;
        logic conv_clk;
        logic [3:0] clocks_left;
        sacrf_pkg::sacrf_state_type state;
        logic done;
    } sacrf_core_state_type;

    sacrf_core_state_type cur;
    sacrf_core_state_type next_cur;
    logic [7:0] fmt_high;
    logic [7:0] fmt_low;

    function automatic logic [7:0] sacrf_cfg_byte(input sacrf_pkg::sacrf_config_type c);
        sacrf_cfg_byte = {c.conv_clock_divider, c.left_justify_select,
            c.eight_bit_mode_enable, c.gain_select};
    endfunction

    // one decode for both the write and the read side, so the two never disagree
    typedef enum {
        SACRF_SEL_NONE,
        SACRF_SEL_CONFIG,
        SACRF_SEL_LOW,
        SACRF_SEL_HIGH
    } sacrf_sel_type;

    function automatic sacrf_sel_type sacrf_decode(input logic [7:0] addr);
        case (addr)
            sacrf_pkg::SACRF_ADDR_CONFIG: begin
                sacrf_decode = SACRF_SEL_CONFIG;
            end
            sacrf_pkg::SACRF_ADDR_LOW: begin
                sacrf_decode = SACRF_SEL_LOW;
            end
            sacrf_pkg::SACRF_ADDR_HIGH: begin
                sacrf_decode = SACRF_SEL_HIGH;
            end
            default: begin
                sacrf_decode = SACRF_SEL_NONE;
            end
        endcase
    endfunction

    // a tick marks the last system clock of each conversion clock period
    function automatic logic sacrf_div_tick(
        input logic [4:0] count,
        input logic [4:0] divider
    );
        // >= rather than ==: a divider lowered mid-period still wraps at once
        sacrf_div_tick = (count >= divider);
    endfunction

    function automatic logic [4:0] sacrf_div_step(
        input logic [4:0] count,
        input logic [4:0] divider
    );
        if (sacrf_div_tick(count, divider)) begin
            sacrf_div_step = 5'h00;
        end else begin
            sacrf_div_step = count + 5'h01;
        end
    endfunction

    // high for the first half of each period; even divider leaves it high one count longer
    function automatic logic sacrf_clk_level(
        input logic [4:0] count,
        input logic [4:0] divider
    );
        sacrf_clk_level = (count <= {1'b0, divider[4:1]});
    endfunction

    // conversion length in conversion clocks; 8-bit mode skips the two lowest bits
    function automatic logic [3:0] sacrf_conv_length(input logic eight_bit);
        if (eight_bit) begin
            sacrf_conv_length = sacrf_pkg::SACRF_CYCLES_10BIT -
                sacrf_pkg::SACRF_CYCLES_SAVED_8BIT;
        end else begin
            sacrf_conv_length = sacrf_pkg::SACRF_CYCLES_10BIT;
        end
    endfunction

    // read data is registered, so the mux looks at state before this edge's writes
    function automatic logic [7:0] sacrf_read_mux(
        input sacrf_sel_type sel,
        input sacrf_core_state_type s
    );
        case (sel)
            SACRF_SEL_CONFIG: begin
                sacrf_read_mux = sacrf_cfg_byte(s.cfg);
            end
            SACRF_SEL_LOW: begin
                sacrf_read_mux = s.result_low_byte;
            end
            SACRF_SEL_HIGH: begin
                sacrf_read_mux = s.result_high_byte;
            end
            default: begin
                sacrf_read_mux = 8'h00;
            end
        endcase
    endfunction

    // the count is checked before it is decremented, so 1 is the final tick
    function automatic logic sacrf_last_tick(input logic [3:0] clocks_left);
        sacrf_last_tick = (clocks_left <= 4'h1);
    endfunction

    // sample the code mode-masked: 8-bit mode converts only the top bits
    sacrf_format u_format (
        .code(cur.cfg.eight_bit_mode_enable ? {analog_code[9:2], 2'h0} : analog_code),
        .left_justify_select(cur.cfg.left_justify_select),
        .eight_bit_mode_enable(cur.cfg.eight_bit_mode_enable),
        .high_byte(fmt_high),
        .low_byte(fmt_low)
    );

    always_comb begin
        logic tick;
        tick = 1'b0;
        next_cur = cur;
        next_cur.done = 1'b0;
        // divider: one tick per (field + 1) system clocks
        tick = sacrf_div_tick(cur.div_count, cur.cfg.conv_clock_divider);
        next_cur.div_count = sacrf_div_step(cur.div_count, cur.cfg.conv_clock_divider);
        // square-ish output: high in the first half of each period
        next_cur.conv_clk = sacrf_clk_level(next_cur.div_count, cur.cfg.conv_clock_divider);
        // register writes; a completing conversion below takes priority on result bytes
        if (sfr_req.write_en) begin
            case (sacrf_decode(sfr_req.addr))
                SACRF_SEL_CONFIG: begin
                    // divider of zero under memory power control is software's concern
                    next_cur.cfg = sfr_req.wdata;
                end
                SACRF_SEL_LOW: next_cur.result_low_byte = sfr_req.wdata;
                SACRF_SEL_HIGH: next_cur.result_high_byte = sfr_req.wdata;
                default: ;
            endcase
        end
        case (cur.state)
            sacrf_pkg::SACRF_IDLE: begin
                if (conv_start) begin
                    next_cur.state = sacrf_pkg::SACRF_CONVERT;
                    next_cur.clocks_left = sacrf_conv_length(cur.cfg.eight_bit_mode_enable);
                end
            end
            sacrf_pkg::SACRF_CONVERT: begin
                if (tick) begin
                    if (sacrf_last_tick(cur.clocks_left)) begin
                        next_cur.state = sacrf_pkg::SACRF_IDLE;
                        next_cur.clocks_left = 4'h0;
                        next_cur.done = 1'b1;
                        // completion wins over a same-cycle software write
                        next_cur.result_high_byte = fmt_high;
                        next_cur.result_low_byte = fmt_low;
                    end else begin
                        next_cur.clocks_left = cur.clocks_left - 4'h1;
                    end
                end
            end
            default: next_cur.state = sacrf_pkg::SACRF_IDLE;
        endcase
        // registered read data; unmapped addresses read zero
        next_cur.rdata = 8'h00;
        if (sfr_req.read_en) begin
            next_cur.rdata = sacrf_read_mux(sacrf_decode(sfr_req.addr), cur);
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cur.cfg <= sacrf_pkg::SACRF_RESET_CONFIG;
            cur.result_high_byte <= sacrf_pkg::SACRF_RESET_HIGH;
            cur.result_low_byte <= sacrf_pkg::SACRF_RESET_LOW;
            cur.rdata <= 8'h00;
            cur.div_count <= 5'h00;
            cur.conv_clk <= 1'b0;
            cur.clocks_left <= 4'h0;
            cur.state <= sacrf_pkg::SACRF_IDLE;
            cur.done <= 1'b0;
        end else begin
            cur <= next_cur;
        end
    end

    assign sfr_rdata = cur.rdata;
    assign conversion_clock = cur.conv_clk;
    assign gain_select = cur.cfg.gain_select;
    assign conv_busy = (cur.state == sacrf_pkg::SACRF_CONVERT);
    assign conv_done = cur.done;
endmodule // sacrf_core
`default_nettype wire

/* File: logic/sacrf_pkg.sv */
// package: register map, field layout, reset values and carriers for the converter control block
package sacrf_pkg;
    localparam logic [7:0] SACRF_ADDR_CONFIG = 8'hBC;
    localparam logic [7:0] SACRF_ADDR_LOW = 8'hBD;
    localparam logic [7:0] SACRF_ADDR_HIGH = 8'hBE;
    localparam logic [7:0] SACRF_RESET_CONFIG = 8'hF9;
    localparam logic [7:0] SACRF_RESET_LOW = 8'h00;
    localparam logic [7:0] SACRF_RESET_HIGH = 8'h00;
    localparam int SACRF_DIV_MSB = 7;
    localparam int SACRF_DIV_LSB = 3;
    localparam int SACRF_LJST_BIT = 2;
    localparam int SACRF_8BIT_BIT = 1;
    localparam int SACRF_GAIN_BIT = 0;
    // conversion clocks per conversion; 8-bit mode takes two fewer
    localparam logic [3:0] SACRF_CYCLES_10BIT = 4'hA;
    localparam logic [3:0] SACRF_CYCLES_SAVED_8BIT = 4'h2;

    typedef struct packed {
        logic [4:0] conv_clock_divider;
        logic left_justify_select;
        logic eight_bit_mode_enable;
        logic gain_select;
    } sacrf_config_type;

    typedef struct packed {
        logic write_en;
        logic read_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sacrf_sfr_req_type;

    typedef enum logic [1:0] {
        SACRF_IDLE,
        SACRF_CONVERT
    } sacrf_state_type;
endpackage

/* File: logic/sacrf_format.sv */
// result formatter: lays a raw code out over the high and low result bytes
`timescale 1ns/1ps
`default_nettype none
module sacrf_format (
    input wire logic [9:0] code,
    input wire logic left_justify_select,
    input wire logic eight_bit_mode_enable,
    output logic [7:0] high_byte,
    output logic [7:0] low_byte
);
    always_comb begin
        if (eight_bit_mode_enable) begin
            // 8-bit code arrives in the top bits of code; justify bit ignored
            high_byte = code[9:2];
            low_byte = 8'h00;
        end else if (left_justify_select) begin
            high_byte = code[9:2];
            low_byte = {code[1:0], 6'h00};
        end else begin
            high_byte = {6'h00, code[9:8]};
            low_byte = code[7:0];
        end
    end
endmodule // sacrf_format
`default_nettype wire

/* File: testbench/sacrf_monitor.sv */
// checker: port properties of the converter control block
`timescale 1ns/1ps
`default_nettype none
module sacrf_monitor (
    input wire logic mclk,
    input wire logic rst_n,
    input wire sacrf_pkg::sacrf_sfr_req_type sfr_req,
    input wire logic conv_start,
    input wire logic gain_select,
    input wire logic conv_busy,
    input wire logic conv_done
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    wire cfg_wr = sfr_req.write_en && sfr_req.addr == sacrf_pkg::SACRF_ADDR_CONFIG;
    property p_gain; cfg_wr |=> gain_select == $past(sfr_req.wdata[0]); endproperty
    a_gain: assert property (p_gain) else $error("gain not from config");
    property p_keep; !cfg_wr |=> $stable(gain_select); endproperty
    a_keep: assert property (p_keep) else $error("gain moved alone");
    property p_start; conv_start && !conv_busy |=> conv_busy; endproperty
    a_start: assert property (p_start) else $error("start not taken");
    // 8 ticks is the shortest legal conversion
    property p_min; $rose(conv_busy) |-> conv_busy[*8]; endproperty
    a_min: assert property (p_min) else $error("conversion too short");
    property p_max; $rose(conv_busy) |-> ##[1:400] !conv_busy; endproperty
    a_max: assert property (p_max) else $error("conversion too long");
    property p_end; $fell(conv_busy) |-> conv_done; endproperty
    a_end: assert property (p_end) else $error("no done at end");
    property p_pulse; conv_done |=> !conv_done; endproperty
    a_pulse: assert property (p_pulse) else $error("done too long");
    property p_cause; conv_done |-> $past(conv_busy) && !conv_busy; endproperty
    a_cause: assert property (p_cause) else $error("done without busy");
    c_conv: cover property ($fell(conv_busy));
    c_gain0: cover property (cfg_wr ##1 !gain_select);
    c_done: cover property (conv_done);
endmodule // sacrf_monitor
bind sacrf_core sacrf_monitor sacrf_monitor_i (.mclk, .rst_n, .sfr_req, .conv_start,
    .gain_select, .conv_busy, .conv_done);
`default_nettype wire

/* File: testbench/testbench.sv */
// self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic mclk, rst_n, conv_start, conversion_clock, gain_select, conv_busy, conv_done;
    sacrf_pkg::sacrf_sfr_req_type sfr_req;
    logic [7:0] sfr_rdata;
    logic [9:0] analog_code;
    int miscompares = 0;
    int total_checks = 0;
    sacrf_core sacrf_core_i (.mclk, .rst_n, .sfr_req, .sfr_rdata, .conv_start, .analog_code,
        .conversion_clock, .gain_select, .conv_busy, .conv_done);
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("checks=%0d mismatches=%0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk) sfr_req <= '{1'b1, 1'b0, a, d};
        @(posedge mclk) sfr_req <= '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk) sfr_req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge mclk) sfr_req <= '0;
        #1 check(sfr_rdata, e);
    endtask
    task automatic conv(input logic [9:0] code, output int n);
        @(posedge mclk) conv_start <= 1'b1;
        analog_code <= code;
        @(posedge mclk) conv_start <= 1'b0;
        n = 0;
        #1;
        while (conv_busy === 1'b1 && n < 500) @(posedge mclk) #1 n++;
        check(conv_done, 1'b1);
    endtask
    task automatic t_regs();
        rd(8'hBC, 8'hF9);
        rd(8'hBD, 8'h00);
        rd(8'hBE, 8'h00);
        check(gain_select, 1'b1);
        wr(8'hBC, 8'h1A);
        rd(8'hBC, 8'h1A);
        check(gain_select, 1'b0);
        wr(8'hBF, 8'h55);
        rd(8'hBF, 8'h00);
    endtask
    task automatic t_clock();
        int n, p, k;
        wr(8'hBC, 8'h18);
        fork
            conv(10'h155, n);
            begin
                // edges are counted on pre-edge values, so no race with the design
                for (k = 0; k < 99 && conversion_clock !== 1'b0; k++) @(posedge mclk);
                for (k = 0; k < 99 && conversion_clock !== 1'b1; k++) @(posedge mclk);
                for (p = 0; p < 99 && conversion_clock !== 1'b0; p++) @(posedge mclk);
                for (k = 0; k < 99 && conversion_clock !== 1'b1; k++) @(posedge mclk);
            end
        join
        check(16'(p + k), 16'h4);
        check(n >= 37 && n <= 40, 1'b1);
    endtask
    task automatic t_format();
        logic [9:0] c;
        int n;
        c = 10'h2D5;
        for (int m = 0; m < 4; m++) begin
            wr(8'hBD, 8'hFF);
            wr(8'hBE, 8'hFF);
            wr(8'hBC, {5'h00, m[1:0], 1'b1});
            conv(c, n);
            check(16'(n), m[0] ? 16'h8 : 16'hA);
            rd(8'hBE, m[0] ? c[9:2] : m[1] ? c[9:2] : {6'h00, c[9:8]});
            rd(8'hBD, m[0] ? 8'h00 : m[1] ? {c[1:0], 6'h00} : c[7:0]);
            c = ~c;
        end
    endtask
    initial forever #4 mclk = ~mclk;
    initial begin
        #100000;
        miscompares++;
        final_report();
    end
    initial begin
        mclk = 1'b0;
        rst_n = 1'b0;
        sfr_req = '0;
        conv_start = 1'b0;
        analog_code = 10'h000;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        t_regs();
        t_clock();
        t_format();
        final_report();
    end
endmodule // testbench
`default_nettype wire
